// ### bench/hv_wake_input_config_tb_top.sv
// self-checking bench of the hv wake input block
`timescale 1ns/1ps
`default_nettype none
module hv_wake_input_config_tb_top;
  typedef struct {
    logic [6:0] ctrl;
    logic [5:0] outs;
  } hvw_row_t;
  localparam logic [7:0] A_CTRL = hvw_pkg::ADDR_CTRL;
  localparam logic [7:0] A_STAT = hvw_pkg::ADDR_STAT;
  localparam logic [7:0] A_MODE = hvw_pkg::ADDR_MODE;
  localparam int F_MIN = hvw_pkg::FILT_MIN_CYC;
  localparam int F_MAX = hvw_pkg::FILT_MAX_CYC;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic timer_switch_on = 1'b0, clk_en = 1'b1;
  logic low_power_mode = 1'b0, other_wake_enabled = 1'b0;
  logic [1:0] drive = 2'd1;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, hv_line, pull_up_en, pull_down_en, meas_route_en;
  logic fail_output_en, fail_output_test, gpio_func_en, high_side_switch_en;
  logic wake_irq_pulse, wake_up_pulse, sleep_enter_pulse, restart_enter_pulse;
  int err_total = 0, comparisons = 0, cyc = 0;
  int irq_n = 0, wup_n = 0, slp_n = 0, rst_n = 0;
  bit hit;
  // ctrl value beside {pull up, pull down, meas route, fail en, fail test, gpio}
  hvw_row_t rows [7] = '{'{7'h00, 6'b000100}, '{7'h01, 6'b010100},
    '{7'h02, 6'b100100}, '{7'h03, 6'b010100}, '{7'h20, 6'b000110},
    '{7'h40, 6'b000101}, '{7'h73, 6'b001000}};

  // clock at 250 MHz
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  hvw_top dut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .hv_wake_input(hv_line),
    .timer_switch_on(timer_switch_on), .low_power_mode(low_power_mode),
    .other_wake_enabled(other_wake_enabled), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .meas_route_en(meas_route_en),
    .fail_output_en(fail_output_en), .fail_output_test(fail_output_test),
    .gpio_func_en(gpio_func_en), .high_side_switch_en(high_side_switch_en),
    .wake_irq_pulse(wake_irq_pulse), .wake_up_pulse(wake_up_pulse),
    .sleep_enter_pulse(sleep_enter_pulse), .restart_enter_pulse(restart_enter_pulse));

  hvw_line_model line_model (.clk_sys(clk_sys), .drive(drive), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .line(hv_line));

  // one-cycle pulses are counted so tests can compare totals
  always @(posedge clk_sys) begin
    if (wake_irq_pulse === 1'b1) irq_n <= irq_n + 1;
    if (wake_up_pulse === 1'b1) wup_n <= wup_n + 1;
    if (sleep_enter_pulse === 1'b1) slp_n <= slp_n + 1;
    if (restart_enter_pulse === 1'b1) rst_n <= rst_n + 1;
  end

  task automatic chk_v(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_n(input string nm, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      err_total++;
      $display("MISMATCH %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // apb transfer; an idle edge first so release and setup never share a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      $display("MISMATCH pready expected 1 seen %b", pready);
      summarize();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_v(nm, exp, rd);
  endtask
  // waits for a wake pulse of either kind, bounded
  task automatic wait_evt(input int lim);
    int base;
    base = irq_n + wup_n;
    cyc = 0;
    hit = 0;
    while (cyc < lim && !hit) begin
      @(posedge clk_sys);
      cyc++;
      hit = (irq_n + wup_n) != base;
    end
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk_v("fail_output_en", 32'h1, {31'h0, fail_output_en});
    rdc("ctrl reset", A_CTRL, 32'h0);
    rdc("status reset", A_STAT, 32'h0);
    $display("test reset done");
    // table of pull and pin function settings, pin held low
    foreach (rows[i]) begin
      wr(A_CTRL, {25'h0, rows[i].ctrl});
      cycles(3);
      chk_v("pin outputs", {26'h0, rows[i].outs}, {26'h0, pull_up_en, pull_down_en,
        meas_route_en, fail_output_en, fail_output_test, gpio_func_en});
      rdc("ctrl kept", A_CTRL, {25'h0, rows[i].ctrl});
    end
    $display("test table done");
    // static rise passes only after the filter time
    wr(A_CTRL, 32'h04);
    @(posedge clk_sys);
    drive <= 2'd2;
    wait_evt(F_MAX + 20);
    chk_n("irq pulses", 1, irq_n);
    chk_n("filter delay in range", 1, int'(cyc >= F_MIN && cyc <= F_MAX));
    rdc("status after rise", A_STAT, 32'h3);
    wr(A_STAT, 32'h1);
    rdc("status cleared", A_STAT, 32'h2);
    // short dip must be discarded
    @(posedge clk_sys);
    drive <= 2'd1;
    cycles(100);
    drive <= 2'd2;
    wait_evt(hvw_pkg::FILT_CYC + 50);
    chk_n("glitch events", 0, int'(hit));
    $display("test static done");
    // automatic pull, then a falling wake in low power
    wr(A_CTRL, 32'h07);
    cycles(3);
    chk_v("auto pull high", 32'h2, {30'h0, pull_up_en, pull_down_en});
    low_power_mode <= 1'b1;
    drive <= 2'd1;
    wait_evt(F_MAX + 20);
    chk_n("wake-up pulses", 1, wup_n);
    chk_n("irq pulses", 1, irq_n);
    cycles(3);
    chk_v("auto pull low", 32'h1, {30'h0, pull_up_en, pull_down_en});
    $display("test auto done");
    // cyclic sense: pin changes only between switch windows
    low_power_mode <= 1'b0;
    wr(A_STAT, 32'h7);
    // timer high-side function set in the same write as cyclic sense
    wr(A_CTRL, 32'h4c);
    @(posedge clk_sys);
    timer_switch_on <= 1'b1;
    cycles(5);
    chk_v("switch on", 32'h1, {31'h0, high_side_switch_en});
    timer_switch_on <= 1'b0;
    cycles(3);
    drive <= 2'd2;
    wait_evt(20);
    chk_n("events outside window", 0, int'(hit));
    timer_switch_on <= 1'b1;
    cycles(5);
    timer_switch_on <= 1'b0;
    wait_evt(10);
    chk_n("irq after window", 2, irq_n);
    $display("test cyclic done");
    // measurement mode with the wake input as sole source
    wr(A_STAT, 32'h7);
    wr(A_CTRL, 32'h14);
    rdc("level held zero", A_STAT, 32'h0);
    @(posedge clk_sys);
    drive <= 2'd1;
    wait_evt(30);
    chk_n("events while measuring", 0, int'(hit));
    wr(A_MODE, 32'h1);
    cycles(3);
    chk_n("restart entries", 1, rst_n);
    chk_n("sleep entries", 0, slp_n);
    rdc("fault flag", A_STAT, 32'h4);
    wr(A_STAT, 32'h4);
    rdc("fault cleared", A_STAT, 32'h0);
    other_wake_enabled <= 1'b1;
    wr(A_MODE, 32'h1);
    cycles(3);
    chk_n("sleep entries", 1, slp_n);
    rdc("ctrl kept", A_CTRL, 32'h14);
    apb(1'b0, 8'h0c, 32'h0);
    chk_v("unmapped error", 32'h1, {31'h0, er});
    chk_v("unmapped data", 32'h0, rd);
    $display("test measure done");
    // frozen enable holds every flop; then a reset in mid-run
    wr(A_CTRL, 32'h40);
    clk_en <= 1'b0;
    timer_switch_on <= 1'b1;
    cycles(3);
    chk_v("frozen switch", 32'h0, {31'h0, high_side_switch_en});
    clk_en <= 1'b1;
    cycles(2);
    chk_v("timer switch", 32'h1, {31'h0, high_side_switch_en});
    reset <= 1'b1;
    cycles(2);
    reset <= 1'b0;
    @(posedge clk_sys);
    chk_v("fail output again", 32'h1, {31'h0, fail_output_en});
    rdc("ctrl after reset", A_CTRL, 32'h0);
    $display("test reset again done");
    summarize();
  end
endmodule
`default_nettype wire

// ### bench/hvw_line_model.sv
// model of the external line on the hv wake pin, with the device pulls
`timescale 1ns/1ps
`default_nettype none
module hvw_line_model (
  // clock
  input wire logic clk_sys,
  // bench drive: 0 open, 1 low, 2 high
  input wire logic [1:0] drive,
  // pull sources of the device
  input wire logic pull_up_en,
  input wire logic pull_down_en,
  // level seen by the comparator
  output logic line
);
  logic noise = 1'b0;
  // an open pin without pull has no defined level, so it wanders
  always_ff @(posedge clk_sys) begin
    noise <= ~noise;
  end
  // pin level from drive and pulls
  always_comb begin
    if (drive == 2'd1) begin
      line = 1'b0;
    end else if (drive == 2'd2) begin
      line = 1'b1;
    end else if (pull_up_en) begin
      line = 1'b1;
    end else if (pull_down_en) begin
      line = 1'b0;
    end else begin
      line = noise;
    end
  end
endmodule
`default_nettype wire

// ### core/hvw_filter.sv
// wake input synchroniser, static filter and cyclic sampler
`timescale 1ns/1ps
`default_nettype none
module hvw_filter #(
  parameter int FILT_CYC = hvw_pkg::FILT_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  // raw comparator output
  input wire logic wake_pin,
  // towards control logic
  hvw_filt_if.filt fl
);
  // refuse a filter time outside its tolerance
  if (FILT_CYC < hvw_pkg::FILT_MIN_CYC || FILT_CYC > hvw_pkg::FILT_MAX_CYC) begin : g_chk
    $error("filter count outside tolerance");
  end
  localparam logic [12:0] LAST = 13'(FILT_CYC - 1);
  logic sync1_reg, sync2_reg, stable_reg, samp_reg, switch_d_reg, edge_reg;
  logic [12:0] cnt_reg;
  hvw_pkg::hvw_filt_st_t st_reg;
  wire logic win_end = switch_d_reg & ~fl.switch_on;

  // two stages before anything looks at the pin
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else if (clk_en) begin
      sync1_reg <= wake_pin;
      sync2_reg <= sync1_reg;
    end
  end

  // cyclic sense sampling window
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      switch_d_reg <= 1'b0;
      samp_reg <= 1'b0;
    end else if (clk_en) begin
      switch_d_reg <= fl.switch_on;
      if (fl.switch_on) begin
        samp_reg <= sync2_reg;
      end
    end
  end

  // level qualification; blocked input never produces an edge
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_reg <= hvw_pkg::FS_STABLE;
      cnt_reg <= 13'h0000;
      stable_reg <= 1'b0;
      edge_reg <= 1'b0;
    end else if (clk_en) begin
      edge_reg <= 1'b0;
      if (fl.block) begin
        st_reg <= hvw_pkg::FS_STABLE;
      end else if (fl.cyc_mode) begin
        st_reg <= hvw_pkg::FS_STABLE;
        if (win_end && samp_reg != stable_reg) begin
          stable_reg <= samp_reg;
          edge_reg <= 1'b1;
        end
      end else begin
        unique case (st_reg)
          hvw_pkg::FS_STABLE: begin
            if (sync2_reg != stable_reg) begin
              st_reg <= hvw_pkg::FS_QUALIFY;
              cnt_reg <= 13'h0000;
            end
          end
          hvw_pkg::FS_QUALIFY: begin
            if (sync2_reg == stable_reg) begin
              st_reg <= hvw_pkg::FS_STABLE;
            end else if (cnt_reg == LAST) begin
              stable_reg <= sync2_reg;
              edge_reg <= 1'b1;
              st_reg <= hvw_pkg::FS_STABLE;
            end else begin
              cnt_reg <= cnt_reg + 13'h0001;
            end
          end
        endcase
      end
    end
  end

  assign fl.level = stable_reg;
  assign fl.edge_pulse = edge_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_cyc_window: assert property (clk_en && fl.cyc_mode && !win_end |=> !edge_reg)
    else $error("cyclic edge outside window end");
  a_cyc_change: assert property (clk_en && fl.cyc_mode && !fl.block && win_end
      && samp_reg != stable_reg |=> edge_reg && stable_reg == $past(samp_reg))
    else $error("cyclic change not reported");
  a_filt_glitch: assert property (clk_en && !fl.cyc_mode
      && st_reg == hvw_pkg::FS_QUALIFY && sync2_reg == stable_reg |=> !edge_reg)
    else $error("glitch accepted");
  a_filt_count: assert property (clk_en && !fl.cyc_mode && !fl.block
      && st_reg == hvw_pkg::FS_QUALIFY && cnt_reg != LAST |=> !edge_reg)
    else $error("level accepted before filter time");
  a_filt_accept: assert property (clk_en && !fl.cyc_mode && !fl.block
      && st_reg == hvw_pkg::FS_QUALIFY && cnt_reg == LAST && sync2_reg != stable_reg
      |=> edge_reg && stable_reg == $past(sync2_reg))
    else $error("stable level not accepted");
endmodule
`default_nettype wire

// ### core/hvw_top.sv
// hv wake input configuration, sensing and measurement control
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module hvw_top #(
  parameter int FILT_CYC = hvw_pkg::FILT_CYC
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // wake pin comparator and timer
  input wire logic hv_wake_input,
  input wire logic timer_switch_on,
  // system state
  input wire logic low_power_mode,
  input wire logic other_wake_enabled,
  // pull sources
  output logic pull_up_en,
  output logic pull_down_en,
  // pin function control
  output logic meas_route_en,
  output logic fail_output_en,
  output logic fail_output_test,
  output logic gpio_func_en,
  output logic high_side_switch_en,
  // wake signalling and mode change
  output logic wake_irq_pulse,
  output logic wake_up_pulse,
  output logic sleep_enter_pulse,
  output logic restart_enter_pulse
);
  logic [6:0] wake_control_reg;
  logic wake_pin_event_flag_reg, fault_reg, level_stat_reg;
  logic pull_up_reg, pull_down_reg;
  logic meas_route_reg, fail_en_reg, fail_test_reg, gpio_reg, high_side_reg;
  logic irq_reg, wup_reg, sleep_reg, restart_reg;
  logic pready_reg, pslverr_reg;
  logic [31:0] prdata_reg;

  hvw_filt_if fif ();

  hvw_filter #(
    .FILT_CYC(FILT_CYC)
  ) u_filter (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_en(clk_en),
    .wake_pin(hv_wake_input),
    .fl(fif.filt)
  );

  // control fields
  wire logic meas = wake_control_reg[hvw_pkg::CTRL_MEAS];
  wire logic wake_en = wake_control_reg[hvw_pkg::CTRL_WAKE_EN];
  wire logic gpio_timer = wake_control_reg[hvw_pkg::CTRL_GPIO_TIMER];
  wire hvw_pkg::hvw_pull_t pull_sel = hvw_pkg::hvw_pull_t'(
      {wake_control_reg[hvw_pkg::CTRL_PULL_HI], wake_control_reg[hvw_pkg::CTRL_PULL_LO]});

  // filter steering
  // cyclic needs high-side timer
  assign fif.cyc_mode = wake_control_reg[hvw_pkg::CTRL_CYCLIC] & gpio_timer;
  assign fif.switch_on = timer_switch_on & gpio_timer;
  assign fif.block = meas;

  // bus phases: write commits at the edge that sees pready high
  wire logic acc = psel & penable;
  wire logic commit = acc & pready_reg;
  wire logic wr_go = commit & pwrite;
  wire logic hit_ctrl = paddr == hvw_pkg::ADDR_CTRL;
  wire logic hit_stat = paddr == hvw_pkg::ADDR_STAT;
  wire logic hit_mode = paddr == hvw_pkg::ADDR_MODE;
  wire logic mapped = hit_ctrl | hit_stat | hit_mode;
  wire logic wr_stat = wr_go & hit_stat;
  wire logic sleep_req = wr_go & hit_mode & pwdata[hvw_pkg::MODE_SLEEP];
  wire logic sole_source = wake_en & ~other_wake_enabled;
  wire logic wake_event = fif.edge_pulse & wake_en & ~meas;

  // read mux, zero for unmapped and reserved bits
  function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic [6:0] c,
                                         input logic [2:0] s);
    rd_mux = 32'h0000_0000;
    if (a == hvw_pkg::ADDR_CTRL) begin
      rd_mux = {25'h0000000, c};
    end else if (a == hvw_pkg::ADDR_STAT) begin
      rd_mux = {29'h00000000, s};
    end
  endfunction

  // apb answer: one wait cycle, then pready for one cycle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      if (acc && !pready_reg) begin
        pready_reg <= 1'b1;
        pslverr_reg <= ~mapped;
        prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux(paddr, wake_control_reg,
            {fault_reg, level_stat_reg, wake_pin_event_flag_reg});
      end else begin
        pready_reg <= 1'b0;
        pslverr_reg <= 1'b0;
      end
    end
  end

  // control register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wake_control_reg <= hvw_pkg::CTRL_RESET;
    end else if (clk_en) begin
      if (wr_go && hit_ctrl) begin
        wake_control_reg <= pwdata[6:0];
      end
    end
  end

  // wake event flag, set beats a same-cycle clear
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wake_pin_event_flag_reg <= 1'b0;
    end else if (clk_en) begin
      if (wake_event) begin
        wake_pin_event_flag_reg <= 1'b1;
      end else if (wr_stat && pwdata[hvw_pkg::STAT_EVENT]) begin
        wake_pin_event_flag_reg <= 1'b0;
      end
    end
  end

  // level status follows the filtered level, held zero while measuring
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      level_stat_reg <= 1'b0;
    end else if (clk_en) begin
      level_stat_reg <= meas ? 1'b0 : fif.level;
    end
  end

  // pull sources, settings ignored while measuring
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pull_up_reg <= 1'b0;
      pull_down_reg <= 1'b0;
    end else if (clk_en) begin
      if (meas) begin
        pull_up_reg <= 1'b0;
        pull_down_reg <= 1'b0;
      end else begin
        unique case (pull_sel)
          hvw_pkg::PULL_NONE: begin
            pull_up_reg <= 1'b0;
            pull_down_reg <= 1'b0;
          end
          hvw_pkg::PULL_DOWN: begin
            pull_up_reg <= 1'b0;
            pull_down_reg <= 1'b1;
          end
          hvw_pkg::PULL_UP: begin
            pull_up_reg <= 1'b1;
            pull_down_reg <= 1'b0;
          end
          hvw_pkg::PULL_AUTO: begin
            pull_up_reg <= fif.level;
            pull_down_reg <= ~fif.level;
          end
        endcase
      end
    end
  end

  // pin function routing
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      meas_route_reg <= 1'b0;
      fail_en_reg <= 1'b1;
      fail_test_reg <= 1'b0;
      gpio_reg <= 1'b0;
      high_side_reg <= 1'b0;
    end else if (clk_en) begin
      meas_route_reg <= meas;
      fail_en_reg <= ~meas;
      fail_test_reg <= wake_control_reg[hvw_pkg::CTRL_FAIL_TEST] & ~meas;
      gpio_reg <= gpio_timer & ~meas;
      high_side_reg <= gpio_timer & timer_switch_on & ~meas;
    end
  end

  // wake signalling by interrupt or by wake-up, chosen by mode
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_reg <= 1'b0;
      wup_reg <= 1'b0;
    end else if (clk_en) begin
      irq_reg <= wake_event & ~low_power_mode;
      wup_reg <= wake_event & low_power_mode;
    end
  end

  // sleep request; refused into restart when measuring with the wake input as sole wake source
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sleep_reg <= 1'b0;
      restart_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else if (clk_en) begin
      sleep_reg <= sleep_req & ~(meas & sole_source);
      restart_reg <= sleep_req & meas & sole_source;
      if (sleep_req && meas && sole_source) begin
        fault_reg <= 1'b1;
      end else if (wr_stat && pwdata[hvw_pkg::STAT_FAULT]) begin
        fault_reg <= 1'b0;
      end
    end
  end

  // outputs straight from flip-flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pull_up_en = pull_up_reg;
  assign pull_down_en = pull_down_reg;
  assign meas_route_en = meas_route_reg;
  assign fail_output_en = fail_en_reg;
  assign fail_output_test = fail_test_reg;
  assign gpio_func_en = gpio_reg;
  assign high_side_switch_en = high_side_reg;
  assign wake_irq_pulse = irq_reg;
  assign wake_up_pulse = wup_reg;
  assign sleep_enter_pulse = sleep_reg;
  assign restart_enter_pulse = restart_reg;

  // checks on the control side
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_pull_select: assert property (clk_en && !meas && pull_sel == hvw_pkg::PULL_DOWN
      |=> pull_down_en && !pull_up_en)
    else $error("pull-down select not applied");
  a_pull_auto: assert property (clk_en && !meas && pull_sel == hvw_pkg::PULL_AUTO
      |=> pull_up_en == $past(fif.level) && pull_down_en == !$past(fif.level))
    else $error("automatic pull does not follow level");
  a_meas_route: assert property (clk_en && meas |=> meas_route_en)
    else $error("measurement not routed");
  a_meas_pins_off: assert property (clk_en && meas
      |=> !fail_output_en && !fail_output_test && !gpio_func_en && !high_side_switch_en)
    else $error("pin function active in measure mode");
  a_meas_block: assert property (clk_en && meas |=> !pull_up_en && !pull_down_en
      ##0 !wake_irq_pulse && !wake_up_pulse)
    else $error("wake path not blocked");
  a_meas_keep_ctrl: assert property (clk_en && meas && wr_go && hit_ctrl
      |=> wake_control_reg == $past(pwdata[6:0]))
    else $error("control write lost in measure mode");
  a_meas_status: assert property (clk_en && meas && !wr_stat
      |=> !level_stat_reg && $stable(wake_pin_event_flag_reg))
    else $error("status updated in measure mode");
  a_sleep_refuse: assert property (clk_en && sleep_req && meas && sole_source
      |=> fault_reg && restart_enter_pulse && !sleep_enter_pulse)
    else $error("sleep not refused");
  a_event_flag: assert property (clk_en && wake_event |=> wake_pin_event_flag_reg)
    else $error("wake event flag not set");
  a_edge_route: assert property (clk_en && wake_event && !low_power_mode
      |=> wake_irq_pulse && !wake_up_pulse)
    else $error("wake edge not signalled by interrupt");
  a_wake_route: assert property (clk_en && wake_event && low_power_mode
      |=> wake_up_pulse && !wake_irq_pulse)
    else $error("wake edge not signalled by wake-up");
  c_refused_sleep: cover property (sleep_req && meas && sole_source);
  c_wake_event: cover property (wake_event ##1 wake_pin_event_flag_reg);
  c_auto_up: cover property (pull_sel == hvw_pkg::PULL_AUTO && pull_up_en);
  c_wake_up: cover property (wake_up_pulse);
endmodule
`default_nettype wire

// ### include/hvw_filt_if.sv
// link between control logic and the wake input filter
`timescale 1ns/1ps
`default_nettype none
interface hvw_filt_if;
  logic cyc_mode;
  logic switch_on;
  logic block;
  logic level;
  logic edge_pulse;
  modport filt (input cyc_mode, switch_on, block, output level, edge_pulse);
  modport ctl (output cyc_mode, switch_on, block, input level, edge_pulse);
endinterface
`default_nettype wire

// ### include/hvw_pkg.sv
// shared constants and types of the hv wake input block
package hvw_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_MODE = 8'h08;
  // control register fields
  localparam int CTRL_W = 7;
  localparam int CTRL_PULL_LO = 0;
  localparam int CTRL_PULL_HI = 1;
  localparam int CTRL_WAKE_EN = 2;
  localparam int CTRL_CYCLIC = 3;
  localparam int CTRL_MEAS = 4;
  localparam int CTRL_FAIL_TEST = 5;
  localparam int CTRL_GPIO_TIMER = 6;
  localparam logic [6:0] CTRL_RESET = 7'h00;
  // status register fields
  localparam int STAT_EVENT = 0;
  localparam int STAT_LEVEL = 1;
  localparam int STAT_FAULT = 2;
  // mode request field
  localparam int MODE_SLEEP = 0;
  // filter timing, times in us, clock period in ps
  localparam int CLK_PERIOD_PS = 4000;
  localparam int FILT_TIME_US = 16;
  localparam int FILT_MIN_US = 13;
  localparam int FILT_MAX_US = 20;
  localparam int FILT_CYC = FILT_TIME_US * 1000000 / CLK_PERIOD_PS;
  localparam int FILT_MIN_CYC = (FILT_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FILT_MAX_CYC = FILT_MAX_US * 1000000 / CLK_PERIOD_PS;
  localparam int CNT_W = 13;
  // pull source selection
  typedef enum logic [1:0] {
    PULL_NONE = 2'b00,
    PULL_DOWN = 2'b01,
    PULL_UP = 2'b10,
    PULL_AUTO = 2'b11
  } hvw_pull_t;
  // static filter states
  typedef enum logic {
    FS_STABLE = 1'b0,
    FS_QUALIFY = 1'b1
  } hvw_filt_st_t;
endpackage
